// file: sfp_top.sv
// Serial programming port of the 4 KB code flash: decoder, array and timers.
// Assumes an external programmer drives SCK and MOSI while ISP_MODE is high.
//
// What this block does
// - Programming works only while ISP_MODE is high; four-byte instructions; enable first.
// - SCK runs at most at one sixteenth of the oscillator rate.
// - MOSI sampled on rising SCK; MISO shifted after falling SCK, MSB first.
// - Enable instruction AC 53 enables programming and echoes 69 in byte four.
// - First byte AC with second byte 100x xxxx erases the whole array.
// - Chip erase lasts up to 500 ms before dependent instructions.
// - Erase fills every location with FF; rewriting needs an erase first.
// - Byte read 20 returns the addressed code byte in byte four.
// - Byte write 40 starts a timed write of byte four at the address.
// - Byte write lasts up to 64 oscillator periods plus 400 us.
// - Reading the byte under write returns its inverted MSB until done.
// - Page read 30 and write 50 move 256 bytes from byte 0 to 255.
// - All 256 bytes after the page address are data before decoding resumes.
// - AC with 1110 00mm sets lock mode: none, level 1, level 2, level 3.
// - Lock read 24 returns lock status in byte four, programmed bits as 1.
`timescale 1ns/1ns
`default_nettype none
module sfp_top
    import sfp_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = sfp_pkg::WR_CYCLES,
    parameter int unsigned ERASE_CYCLES = sfp_pkg::ERASE_CYCLES,
    // Identity bytes, values arbitrary
    parameter logic [7:0] SIG_MAKER = 8'h5a,
    parameter logic [7:0] SIG_PART = 8'ha5,
    parameter logic [7:0] SIG_REV = 8'h3c
) (
    // Oscillator clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Programming mode pin, high while programming
    input wire logic ISP_MODE,
    // Serial link
    input wire logic SCK,
    input wire logic MOSI,
    output logic MISO,
    output logic MISO_OE,
    // Status
    output logic PROG_EN,
    output logic FLASH_BUSY,
    output logic [2:0] LOCK_BITS
);
    import sfp_pkg::*;

    typedef struct packed {
        sfp_phase_t phase;
        logic tg_prev;
        logic enabled;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] idx;
        logic [7:0] tx;
        logic [2:0] locks;
        logic [31:0] busy_cnt;
        logic sweep;
        logic [ADDR_W-1:0] erase_addr;
        logic erasing;
        logic writing;
        logic [ADDR_W-1:0] last_addr;
        logic [7:0] last_data;
    } sfp_core_t;

    sfp_core_t st_r;
    sfp_core_t st_nxt;
    sfp_link_if link();

    logic [7:0] mem [MEM_DEPTH];
    logic mode_q;
    logic tgl_q;
    logic sck_rst_n;
    logic rx_ev;
    logic busy;
    logic mem_we;
    logic mem_fill;
    logic [ADDR_W-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] pg_addr;
    logic [ADDR_W-1:0] pg_next;

    // Identity byte chosen by the address nibble
    function automatic logic [7:0] sig_byte(input logic [3:0] sel);
        logic [7:0] v;
        v = 8'h00;
        unique case (sel)
            4'h0: v = SIG_MAKER;
            4'h1: v = SIG_PART;
            4'h2: v = SIG_REV;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // SCK side held in reset outside programming mode
    assign sck_rst_n = RST_N & ISP_MODE;

    sfp_shifter u_shift (
        .sck(SCK),
        .rst_n(sck_rst_n),
        .mosi(MOSI),
        .miso(MISO),
        .link(link.shift)
    );

    sfp_sync u_mode_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .d(ISP_MODE),
        .q(mode_q)
    );

    // Byte strobe crosses as a toggle
    sfp_sync u_tgl_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .d(link.rx_tgl),
        .q(tgl_q)
    );

    // Toggle edge is seen some cycles after the byte, well inside an SCK phase
    assign rx_ev = tgl_q ^ st_r.tg_prev;
    assign busy = (st_r.busy_cnt != 32'h0) | st_r.sweep;

    // Addresses of the byte instruction and of the page instruction bytes
    assign rd_addr = sfp_addr(st_r.b2[3:0], link.rx_byte);
    assign pg_addr = sfp_addr(st_r.b2[3:0], st_r.idx);
    assign pg_next = sfp_addr(st_r.b2[3:0], st_r.idx + 8'h1);

    always_comb begin
        st_nxt = st_r;
        mem_we = 1'b0;
        mem_fill = 1'b0;
        mem_wa = '0;
        mem_wd = 8'h00;
        st_nxt.tg_prev = tgl_q;

        // Self-timed cycles
        if (st_r.busy_cnt != 32'h0) begin
            st_nxt.busy_cnt = st_r.busy_cnt - 32'h1;
        end
        // Erase sweep fills the array
        if (st_r.sweep) begin
            mem_fill = 1'b1;
            mem_wa = st_r.erase_addr;
            st_nxt.erase_addr = st_r.erase_addr + 12'h1;
            if (&st_r.erase_addr) begin
                st_nxt.sweep = 1'b0;
            end
        end
        if ((st_nxt.busy_cnt == 32'h0) && !st_nxt.sweep) begin
            st_nxt.erasing = 1'b0;
            st_nxt.writing = 1'b0;
        end

        if (!mode_q) begin
            // Leaving programming mode drops the enable
            st_nxt.enabled = 1'b0;
            st_nxt.phase = PH_CMD;
            st_nxt.tx = 8'h00;
        end else if (rx_ev) begin
            unique case (st_r.phase)
                PH_CMD: begin
                    st_nxt.b1 = link.rx_byte;
                    st_nxt.phase = PH_HI;
                    st_nxt.tx = 8'h00;
                end
                PH_HI: begin
                    st_nxt.b2 = link.rx_byte;
                    st_nxt.tx = 8'h00;
                    st_nxt.phase = PH_LO;
                    // Page instructions go straight to data
                    if (st_r.enabled &&
                        ((st_r.b1 == OP_RD_PAGE) || (st_r.b1 == OP_WR_PAGE))) begin
                        st_nxt.phase = PH_PAGE;
                        st_nxt.idx = 8'h00;
                        if ((st_r.b1 == OP_RD_PAGE) && !st_r.erasing) begin
                            st_nxt.tx = mem[sfp_addr(link.rx_byte[3:0], 8'h00)];
                        end
                    end
                end
                PH_LO: begin
                    st_nxt.b3 = link.rx_byte;
                    st_nxt.phase = PH_DATA;
                    st_nxt.tx = 8'h00;
                    if ((st_r.b1 == OP_ENABLE_B1) && (st_r.b2 == OP_ENABLE_B2)) begin
                        st_nxt.tx = ENABLE_ECHO;
                    end else if (st_r.enabled) begin
                        unique case (st_r.b1)
                            OP_RD_BYTE: begin
                                if (st_r.erasing) begin
                                    st_nxt.tx = ERASE_READ;
                                end else if (st_r.writing && (rd_addr == st_r.last_addr)) begin
                                    // Data polling
                                    st_nxt.tx = {~st_r.last_data[7], st_r.last_data[6:0]};
                                end else begin
                                    st_nxt.tx = mem[rd_addr];
                                end
                            end
                            OP_RD_LOCK: begin
                                st_nxt.tx[LOCK_LSB +: 3] = st_r.locks;
                            end
                            OP_RD_SIG: begin
                                st_nxt.tx = sig_byte(st_r.b2[3:0]);
                            end
                            default: begin
                                st_nxt.tx = 8'h00;
                            end
                        endcase
                    end
                end
                PH_DATA: begin
                    // Fourth byte closes the instruction
                    st_nxt.phase = PH_CMD;
                    st_nxt.tx = 8'h00;
                    if ((st_r.b1 == OP_ENABLE_B1) && (st_r.b2 == OP_ENABLE_B2)) begin
                        st_nxt.enabled = 1'b1;
                    end else if (st_r.enabled && !busy) begin
                        if ((st_r.b1 == OP_ENABLE_B1) && (st_r.b2[7:5] == ERASE_TAG)) begin
                            // Whole-array erase also clears the locks
                            st_nxt.sweep = 1'b1;
                            st_nxt.erase_addr = '0;
                            st_nxt.erasing = 1'b1;
                            st_nxt.busy_cnt = ERASE_CYCLES;
                            st_nxt.locks = 3'h0;
                        end else if ((st_r.b1 == OP_ENABLE_B1) &&
                                     (st_r.b2[7:2] == LOCK_TAG)) begin
                            // Levels only rise one step at a time
                            unique case (st_r.b2[1:0])
                                LOCK_MODE_L1: st_nxt.locks[0] = 1'b1;
                                LOCK_MODE_L2: st_nxt.locks[1] = st_r.locks[0];
                                LOCK_MODE_L3: st_nxt.locks[2] = st_r.locks[1];
                                default: st_nxt.locks = st_r.locks;
                            endcase
                        end else if (st_r.b1 == OP_WR_BYTE) begin
                            // Timed byte write
                            mem_we = 1'b1;
                            mem_wa = sfp_addr(st_r.b2[3:0], st_r.b3);
                            mem_wd = link.rx_byte;
                            st_nxt.last_addr = sfp_addr(st_r.b2[3:0], st_r.b3);
                            st_nxt.last_data = link.rx_byte;
                            st_nxt.writing = 1'b1;
                            st_nxt.busy_cnt = WRITE_CYCLES;
                        end
                    end
                end
                PH_PAGE: begin
                    // Every byte is data until byte 255
                    st_nxt.idx = st_r.idx + 8'h1;
                    st_nxt.tx = 8'h00;
                    if ((st_r.b1 == OP_WR_PAGE) && !st_r.erasing) begin
                        mem_we = 1'b1;
                        mem_wa = pg_addr;
                        mem_wd = link.rx_byte;
                    end
                    if (st_r.idx == PAGE_LAST) begin
                        st_nxt.phase = PH_CMD;
                    end else if ((st_r.b1 == OP_RD_PAGE) && !st_r.erasing) begin
                        st_nxt.tx = mem[pg_next];
                    end
                end
                default: begin
                    st_nxt.phase = PH_CMD;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Flash cells only clear bits until erased
    always_ff @(posedge CLK) begin
        if (mem_fill) begin
            mem[mem_wa] <= ERASED;
        end else if (mem_we) begin
            mem[mem_wa] <= mem[mem_wa] & mem_wd;
        end
    end

    assign link.tx_byte = st_r.tx;
    assign MISO_OE = mode_q;
    assign PROG_EN = st_r.enabled;
    assign FLASH_BUSY = st_r.erasing | st_r.writing;
    assign LOCK_BITS = st_r.locks;
endmodule
`default_nettype wire

// file: sfp_pkg.sv
// Constants, types and helpers of the serial flash programming port.
// Assumes CLK is the device oscillator at 250 MHz.
package sfp_pkg;

    // Instruction bytes
    localparam logic [7:0] OP_ENABLE_B1 = 8'hac;
    localparam logic [7:0] OP_ENABLE_B2 = 8'h53;
    localparam logic [7:0] ENABLE_ECHO = 8'h69;
    localparam logic [7:0] OP_RD_BYTE = 8'h20;
    localparam logic [7:0] OP_WR_BYTE = 8'h40;
    localparam logic [7:0] OP_RD_PAGE = 8'h30;
    localparam logic [7:0] OP_WR_PAGE = 8'h50;
    localparam logic [7:0] OP_RD_LOCK = 8'h24;
    localparam logic [7:0] OP_RD_SIG = 8'h28;
    localparam logic [2:0] ERASE_TAG = 3'h4;
    localparam logic [5:0] LOCK_TAG = 6'h38;

    // Array layout and fixed values
    localparam int ADDR_W = 12;
    localparam int MEM_DEPTH = 4096;
    localparam logic [7:0] PAGE_LAST = 8'hff;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [7:0] ERASE_READ = 8'h00;
    localparam int LOCK_LSB = 2;
    localparam logic [1:0] LOCK_MODE_L1 = 2'h1;
    localparam logic [1:0] LOCK_MODE_L2 = 2'h2;
    localparam logic [1:0] LOCK_MODE_L3 = 2'h3;

    // Timing, in oscillator periods and real units
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCK_IDLE_OSC = 64;
    localparam int SCK_RATIO = 16;
    localparam int SCK_PHASE_OSC = 8;
    localparam int WR_OSC = 64;
    localparam int WR_TIME_US = 400;
    localparam int ERASE_TIME_MS = 500;
    localparam int WR_CYCLES = WR_OSC + (WR_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES = (ERASE_TIME_MS * 1000000) / CLK_PERIOD_NS;

    // Position inside one instruction
    typedef enum logic [2:0] {
        PH_CMD,
        PH_HI,
        PH_LO,
        PH_DATA,
        PH_PAGE
    } sfp_phase_t;

    function automatic logic [ADDR_W-1:0] sfp_addr(input logic [3:0] hi, input logic [7:0] lo);
        return {hi, lo};
    endfunction

endpackage

// file: sfp_link_if.sv
// Byte carrier between the SCK-side shifter and the oscillator-side core.
// Assumes tx_byte is held stable while the shifter may load it.
`timescale 1ns/1ns
`default_nettype none
interface sfp_link_if;
    logic [7:0] rx_byte;
    logic rx_tgl;
    logic [7:0] tx_byte;
    modport shift(output rx_byte, output rx_tgl, input tx_byte);
    modport core(input rx_byte, input rx_tgl, output tx_byte);
endinterface
`default_nettype wire

// file: sfp_sync.sv
// Three-stage synchroniser with agreement filter for one level.
// Assumes d is asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module sfp_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level in and filtered level out
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } sfp_sync_t;

    sfp_sync_t st_r;
    sfp_sync_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.q = st_r.s3;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q;
endmodule
`default_nettype wire

// file: sfp_shifter.sv
// Serial shifter running on SCK: bytes in on rising, bytes out on falling.
// Assumes rst_n is low whenever programming mode is off.
`timescale 1ns/1ns
`default_nettype none
module sfp_shifter (
    // Link clock and reset
    input wire logic sck,
    input wire logic rst_n,
    // Serial lines
    input wire logic mosi,
    output logic miso,
    // Byte carrier
    sfp_link_if.shift link
);
    typedef struct packed {
        logic [2:0] cnt;
        logic [6:0] sh;
        logic [7:0] rx;
        logic tgl;
    } sfp_rise_t;

    sfp_rise_t rise_r;
    sfp_rise_t rise_nxt;
    logic [7:0] out_r;
    logic [7:0] out_nxt;

    always_comb begin
        rise_nxt = rise_r;
        rise_nxt.cnt = rise_r.cnt + 3'h1;
        rise_nxt.sh = {rise_r.sh[5:0], mosi};
        if (rise_r.cnt == 3'h7) begin
            rise_nxt.rx = {rise_r.sh, mosi};
            rise_nxt.tgl = ~rise_r.tgl;
        end
    end

    always_comb begin
        out_nxt = {out_r[6:0], 1'b0};
        if (rise_r.cnt == 3'h0) begin
            out_nxt = link.tx_byte;
        end
    end

    // Sample on rising SCK
    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            rise_r <= '0;
        end else begin
            rise_r <= rise_nxt;
        end
    end

    // Shift out after falling SCK, MSB first
    always_ff @(negedge sck or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= '0;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign miso = out_r[7];
    assign link.rx_byte = rise_r.rx;
    assign link.rx_tgl = rise_r.tgl;
endmodule
`default_nettype wire

// file: sfp_checker.sv
// Port assertions of the serial programming port.
// Assumes CLK is the oscillator and SCK runs far slower.
`timescale 1ns/1ns
`default_nettype none
module sfp_checker #(
    parameter int unsigned WRITE_CYCLES = 50,
    parameter int unsigned ERASE_CYCLES = 100
) (
    // Clock, reset, mode
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic ISP_MODE,
    // Serial link
    input wire logic SCK,
    input wire logic MOSI,
    input wire logic MISO,
    input wire logic MISO_OE,
    // Status
    input wire logic PROG_EN,
    input wire logic FLASH_BUSY,
    input wire logic [2:0] LOCK_BITS
);
    localparam int unsigned SPAN = (ERASE_CYCLES > 4096) ? ERASE_CYCLES : 4096;
    int unsigned busy_cnt_r;

    // Length of the current busy stretch
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= FLASH_BUSY ? busy_cnt_r + 1 : 0;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_oe_follows_mode: assert property ($rose(ISP_MODE) |-> ##[1:8] MISO_OE)
        else $error("MISO_OE late after mode entry");
    a_mode_off_clears: assert property (!ISP_MODE [*6] |-> !MISO_OE && !PROG_EN)
        else $error("outputs still on after mode exit");
    a_miso_quiet: assert property (!ISP_MODE |-> !MISO)
        else $error("MISO not low outside mode");
    a_miso_on_fall: assert property (ISP_MODE && $past(ISP_MODE) && $changed(MISO)
        |-> $fell(SCK))
        else $error("MISO moved away from falling SCK");
    a_busy_length: assert property ($fell(FLASH_BUSY) |-> busy_cnt_r inside
        {[WRITE_CYCLES - 1 : WRITE_CYCLES + 1], [SPAN - 1 : SPAN + 1]})
        else $error("busy stretch has wrong length");
    a_busy_bound: assert property (busy_cnt_r <= SPAN + 1)
        else $error("busy stretch too long");
    a_busy_needs_en: assert property ($rose(FLASH_BUSY) |-> PROG_EN)
        else $error("busy without programming enabled");
    a_lock_two_order: assert property ($rose(LOCK_BITS[1]) |-> LOCK_BITS[0])
        else $error("lock level 2 before level 1");
    a_lock_three_order: assert property ($rose(LOCK_BITS[2]) |-> LOCK_BITS[1])
        else $error("lock level 3 before level 2");
    a_lock_kept: assert property ($fell(LOCK_BITS[0])
        |-> ##[0:1] (FLASH_BUSY || $past(FLASH_BUSY, 2)))
        else $error("lock bit dropped without erase");
endmodule
`default_nettype wire

// file: sfp_prog_model.sv
// External programmer model: serial master on SCK and MOSI.
// Assumes lck is a free 6 ns tick; SCK moves only inside bytes.
`timescale 1ns/1ns
`default_nettype none
module sfp_prog_model (
    // Tick
    input wire logic lck,
    // Serial lines
    output logic sck,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    // 6 ticks is 36 ns, above 8 oscillator periods
    localparam int PHASE = 6;

    initial begin
        sck = 1'b0;
        mosi = 1'b0;
    end

    // One byte out and in, MSB first
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
        @(posedge lck);
        for (int i = 7; i >= 0; i--) begin
            mosi = d[i];
            repeat (PHASE) @(posedge lck);
            sck = 1'b1;
            q[i] = miso_oe ? miso : ~miso;
            repeat (PHASE) @(posedge lck);
            sck = 1'b0;
        end
        mosi = ~d[0];
    endtask
endmodule
`default_nettype wire

// file: test_serial_isp_flash_programmer.sv
// Self-checking bench of the serial programming port.
// Assumes package, design, checker and programmer model compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_serial_isp_flash_programmer;
    import sfp_pkg::*;
    localparam int unsigned WR_CYC = 1200;
    localparam int unsigned ER_CYC = 100;
    // Identity values, arbitrary
    localparam logic [7:0] SIG_A = 8'h17;
    localparam logic [7:0] SIG_B = 8'h2e;
    localparam logic [7:0] SIG_C = 8'h4b;
    localparam int LIMIT = 105000;
    localparam logic [1:0] MODES [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    logic CLK, RST_N, ISP_MODE, SCK, MOSI, MISO, MISO_OE, PROG_EN, FLASH_BUSY, lck;
    logic [2:0] LOCK_BITS, locks;
    logic [31:0] seed;
    logic [7:0] a, d, lo;
    logic [3:0] hi;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;

    sfp_top #(.WRITE_CYCLES(WR_CYC), .ERASE_CYCLES(ER_CYC), .SIG_MAKER(SIG_A),
        .SIG_PART(SIG_B), .SIG_REV(SIG_C)) u_dut (
        .CLK(CLK), .RST_N(RST_N), .ISP_MODE(ISP_MODE), .SCK(SCK), .MOSI(MOSI),
        .MISO(MISO), .MISO_OE(MISO_OE), .PROG_EN(PROG_EN), .FLASH_BUSY(FLASH_BUSY),
        .LOCK_BITS(LOCK_BITS));
    sfp_prog_model u_prog (.lck(lck), .sck(SCK), .mosi(MOSI), .miso(MISO),
        .miso_oe(MISO_OE));

    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    initial begin
        lck = 1'b0;
        #1;
        forever #3 lck = ~lck;
    end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [7:0] pat(input int k);
        return k[7:0] * 8'h25 + 8'h0b;
    endfunction
    function automatic logic [7:0] sig_of(input int s);
        case (s)
            0: return SIG_A;
            1: return SIG_B;
            2: return SIG_C;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [2:0] lock_next(input logic [2:0] l, input logic [1:0] m);
        case (m)
            2'h1: return l | 3'h1;
            2'h2: return l[0] ? (l | 3'h2) : l;
            2'h3: return l[1] ? (l | 3'h4) : l;
            default: return l;
        endcase
    endfunction

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flag(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic instr(input logic [7:0] b1, b2, b3, b4, output logic [7:0] q);
        u_prog.xbyte(b1, q);
        u_prog.xbyte(b2, q);
        u_prog.xbyte(b3, q);
        u_prog.xbyte(b4, q);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 6000 && FLASH_BUSY !== 1'b0; i++) @(negedge CLK);
        chk_flag("busy_end", 1'b0, FLASH_BUSY);
    endtask
    task automatic close_out();
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        RST_N = 1'b0;
        ISP_MODE = 1'b0;
        seed = 32'h00003e6a;
        locks = 3'h0;
        repeat (3) @(negedge CLK);
        RST_N = 1'b1;
        @(negedge CLK);
        chk_flag("prog_en", 1'b0, PROG_EN);
        chk_byte("locks", 8'h00, {5'h0, LOCK_BITS});
        ISP_MODE = 1'b1;
        repeat (SCK_IDLE_OSC + 4) @(negedge CLK);
        chk_flag("miso_oe", 1'b1, MISO_OE);
        instr(OP_RD_SIG, 8'h00, 8'h00, rnd(), a);
        chk_byte("pre_enable", 8'h00, a);
        instr(OP_ENABLE_B1, OP_ENABLE_B2, rnd(), rnd(), a);
        chk_byte("echo", ENABLE_ECHO, a);
        repeat (8) @(negedge CLK);
        chk_flag("prog_en", 1'b1, PROG_EN);
        d = rnd();
        instr(OP_ENABLE_B1, {ERASE_TAG, d[4:0]}, rnd(), rnd(), a);
        repeat (2) @(negedge CLK);
        chk_flag("erase_busy", 1'b1, FLASH_BUSY);
        instr(OP_RD_BYTE, {4'h0, d[3:0]}, rnd(), 8'h00, a);
        chk_byte("erase_read", ERASE_READ, a);
        wait_idle();
        instr(OP_RD_BYTE, {4'h0, d[7:4]}, rnd(), 8'h00, a);
        chk_byte("erased", ERASED, a);
        for (int i = 0; i < 2; i++) begin
            d = rnd() % 8'h0f;
            hi = d[3:0];
            // Second address never all ones, so neither it nor its inverse hits the first
            lo = (i == 0) ? 8'hff : ((rnd() & 8'h7e) | 8'h01);
            d = rnd();
            instr(OP_WR_BYTE, {4'h0, hi}, lo, d, a);
            if (i == 0) begin
                instr(OP_RD_BYTE, {4'h0, hi}, lo, 8'h00, a);
                chk_byte("poll", {~d[7], d[6:0]}, a);
            end else begin
                instr(OP_WR_BYTE, {4'h0, hi}, ~lo, ~d, a);
            end
            wait_idle();
            instr(OP_RD_BYTE, {4'h0, hi}, lo, 8'h00, a);
            chk_byte("cell", d, a);
            if (i == 1) begin
                instr(OP_RD_BYTE, {4'h0, hi}, ~lo, 8'h00, a);
                chk_byte("busy_write", ERASED, a);
            end
        end
        u_prog.xbyte(OP_WR_PAGE, a);
        u_prog.xbyte(8'h0f, a);
        for (int k = 0; k < 256; k++) u_prog.xbyte(pat(k), a);
        u_prog.xbyte(OP_RD_PAGE, a);
        u_prog.xbyte(8'h0f, a);
        for (int k = 0; k < 256; k++) begin
            u_prog.xbyte(rnd(), a);
            chk_byte("page", pat(k), a);
        end
        for (int s = 0; s < 4; s++) begin
            instr(OP_RD_SIG, 8'(s), 8'h00, 8'h00, a);
            chk_byte("signature", sig_of(s), a);
        end
        // Modes raised in ascending order only
        for (int m = 0; m < 5; m++) begin
            instr(OP_ENABLE_B1, {LOCK_TAG, MODES[m]}, rnd(), rnd(), a);
            locks = lock_next(locks, MODES[m]);
            repeat (8) @(negedge CLK);
            chk_byte("lock_bits", {5'h0, locks}, {5'h0, LOCK_BITS});
            instr(OP_RD_LOCK, rnd(), rnd(), 8'h00, a);
            chk_byte("lock_read", {3'h0, locks, 2'h0}, a);
        end
        ISP_MODE = 1'b0;
        repeat (8) @(negedge CLK);
        chk_flag("prog_en_off", 1'b0, PROG_EN);
        chk_byte("locks_kept", {5'h0, locks}, {5'h0, LOCK_BITS});
        ISP_MODE = 1'b1;
        repeat (SCK_IDLE_OSC + 4) @(negedge CLK);
        instr(OP_RD_LOCK, 8'h00, 8'h00, 8'h00, a);
        chk_byte("locked_out", 8'h00, a);
        close_out();
    end
endmodule

bind sfp_top sfp_checker #(.WRITE_CYCLES(WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_chk (
    .CLK(CLK), .RST_N(RST_N), .ISP_MODE(ISP_MODE), .SCK(SCK), .MOSI(MOSI), .MISO(MISO),
    .MISO_OE(MISO_OE), .PROG_EN(PROG_EN), .FLASH_BUSY(FLASH_BUSY), .LOCK_BITS(LOCK_BITS));
`default_nettype wire
